// *** include/lo_cond_pkg.sv ***
// Overview of operation
// RULE1 - Analog output in logic mode drives its minimum level for logic 0
// RULE2 - Analog output in logic mode drives its maximum level for logic 1
// RULE3 - Output turns on only after the activation delay, 0 to 9999 ms, default 0
// RULE4 - Activation delay forced to zero for fault-free and all contactor assignments
// RULE5 - Output reverts only after the holding time, 0 to 9999 ms, default 0
// RULE6 - Holding time forced to zero for fault-free, brake, precharge, line contactor
// RULE7 - Positive polarity, the default, gives logic 1 while the event is true
// RULE8 - Negative polarity gives logic 0 while the event is true, 1 otherwise
// RULE9 - Polarity locked positive for fault-free, brake, precharge, line; negative refused
// RULE10 - Default assignment is output contactor control
// RULE11 - Contactor selections only set by application configuration, only reported here
// RULE12 - Counters advance on a 1 ms tick and restart if the event reverts
package lo_cond_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  DELAY_OFF     = 8'h04;
  localparam logic [7:0]  HOLD_OFF      = 8'h08;
  localparam logic [7:0]  STATUS_OFF    = 8'h0c;
  localparam logic [7:0]  APPFN_OFF     = 8'h10;

  localparam int          CTRL_POL_BIT  = 4;
  localparam int          CTRL_SEL_BIT  = 5;
  localparam int          ST_REFUSE_BIT = 3;

  // ****************************************
  // Assignments
  // ****************************************
  localparam logic [3:0]  ASG_NONE      = 4'h0;
  localparam logic [3:0]  ASG_FAULTFREE = 4'h1;
  localparam logic [3:0]  ASG_BRAKE     = 4'h2;
  localparam logic [3:0]  ASG_LINE      = 4'h3;
  localparam logic [3:0]  ASG_OUTPUT    = 4'h4;
  localparam logic [3:0]  ASG_PRECHG    = 4'h5;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [3:0]  ASSIGN_RST    = ASG_OUTPUT;
  localparam logic        POL_RST       = 1'b0;
  localparam logic        SEL_RST       = 1'b1;
  localparam logic [13:0] DELAY_RST     = 14'h0000;
  localparam logic [13:0] HOLD_RST      = 14'h0000;
  localparam logic [13:0] TIME_MAX_MS   = 14'h270f;
  localparam logic [15:0] AO_MIN        = 16'h0000;
  localparam logic [15:0] AO_MAX        = 16'hffff;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          TICK_NS       = 1000000;
  localparam int          TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    TM_OFF  = 2'b00,
    TM_ARM  = 2'b01,
    TM_ON   = 2'b10,
    TM_HOLD = 2'b11
  } tm_state_e;

endpackage : lo_cond_pkg

// *** src/ms_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen
  import lo_cond_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  // ****************************************
  // Divider
  // ****************************************
  always_comb
  begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 16'h0001;
    if (cnt_q == 16'(CYCLES - 1))
    begin
      cnt_d  = 16'h0000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : ms_tick_gen
`default_nettype wire

// *** src/edge_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module edge_timer
  import lo_cond_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        event_in,
  input  wire logic [13:0] delay_ms,
  input  wire logic [13:0] hold_ms,
  output logic             active
);

  tm_state_e   st_q;
  tm_state_e   st_d;
  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic [13:0] cnt_inc;

  // ****************************************
  // Delay and hold sequencing
  // ****************************************
  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    cnt_inc = cnt_q + 14'h0001;
    case (st_q)
      TM_OFF:
      begin
        cnt_d = 14'h0000;
        if (event_in)
          st_d = (delay_ms == 14'h0000) ? TM_ON : TM_ARM; // RULE3
      end
      TM_ARM:
      begin
        if (!event_in)
        begin
          st_d  = TM_OFF; // RULE12
          cnt_d = 14'h0000;
        end
        else if (tick || (delay_ms == 14'h0000))
        begin
          if (cnt_inc >= delay_ms)
          begin
            st_d  = TM_ON; // RULE3
            cnt_d = 14'h0000;
          end
          else
            cnt_d = cnt_inc; // RULE12
        end
      end
      TM_ON:
      begin
        cnt_d = 14'h0000;
        if (!event_in)
          st_d = (hold_ms == 14'h0000) ? TM_OFF : TM_HOLD; // RULE5
      end
      TM_HOLD:
      begin
        if (event_in)
        begin
          st_d  = TM_ON; // RULE12
          cnt_d = 14'h0000;
        end
        else if (tick || (hold_ms == 14'h0000))
        begin
          if (cnt_inc >= hold_ms)
          begin
            st_d  = TM_OFF; // RULE5
            cnt_d = 14'h0000;
          end
          else
            cnt_d = cnt_inc;
        end
      end
      default:
      begin
        st_d  = TM_OFF;
        cnt_d = 14'h0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= TM_OFF;
      cnt_q <= 14'h0000;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign active = (st_q == TM_ON) || (st_q == TM_HOLD);

  // ****************************************
  // Checks
  // ****************************************
  property p_rise_after_delay;
    @(posedge pclk) disable iff (!presetn)
    $rose(active) |-> $past(event_in) && ($past(delay_ms) == 14'h0000 || $past(tick));
  endproperty
  a_rise_after_delay: assert property (p_rise_after_delay) // RULE3
    else $error("output rose without delay elapsing");

  property p_fall_after_hold;
    @(posedge pclk) disable iff (!presetn)
    $fell(active) |-> !$past(event_in) && ($past(hold_ms) == 14'h0000 || $past(tick));
  endproperty
  a_fall_after_hold: assert property (p_fall_after_hold) // RULE5
    else $error("output fell without hold elapsing");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    (st_q == TM_ARM && !event_in) |=> (st_q == TM_OFF && cnt_q == 14'h0000);
  endproperty
  a_restart: assert property (p_restart) // RULE12
    else $error("delay counter did not restart");

endmodule : edge_timer
`default_nettype wire

// *** src/logic_output_conditioner.sv ***
`timescale 1ns/1ps
`default_nettype none
module logic_output_conditioner
  import lo_cond_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] event_in,
  input  wire logic [15:0] analog_level_in,
  output logic             logic_out,
  output logic [15:0]      first_analog_output
);

  logic [3:0]  assign_q;
  logic [3:0]  assign_d;
  logic        output_polarity_q;
  logic        output_polarity_d;
  logic        analog_as_logic_select_q;
  logic        analog_as_logic_select_d;
  logic [13:0] activation_delay_q;
  logic [13:0] activation_delay_d;
  logic [13:0] holding_time_q;
  logic [13:0] holding_time_d;
  logic        refused_q;
  logic        refused_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        logic_out_q;
  logic        logic_out_d;
  logic [15:0] ao_q;
  logic [15:0] ao_d;
  logic        tick;
  logic        ev_sel;
  logic        tm_active;
  logic        delay_forced;
  logic        hold_forced;
  logic        pol_locked;
  logic        active_low_polarity;
  logic [13:0] delay_eff;
  logic [13:0] hold_eff;
  logic        wr_en;
  logic        setup;
  logic        refuse_ev;
  logic [3:0]  new_asg;
  logic        new_locked;

  // ****************************************
  // Assignment decode
  // ****************************************
  function automatic logic is_contactor(input logic [3:0] a);
    is_contactor = (a == ASG_BRAKE) || (a == ASG_LINE) ||
                   (a == ASG_OUTPUT) || (a == ASG_PRECHG);
  endfunction : is_contactor

  function automatic logic is_locked(input logic [3:0] a);
    is_locked = (a == ASG_FAULTFREE) || (a == ASG_BRAKE) ||
                (a == ASG_LINE) || (a == ASG_PRECHG);
  endfunction : is_locked

  assign ev_sel       = (assign_q == ASG_NONE) ? 1'b0 : event_in[assign_q];
  assign delay_forced = is_contactor(assign_q) || (assign_q == ASG_FAULTFREE); // RULE4
  assign hold_forced  = is_locked(assign_q); // RULE6
  assign pol_locked   = is_locked(assign_q); // RULE9
  assign delay_eff    = delay_forced ? 14'h0000 : activation_delay_q; // RULE4
  assign hold_eff     = hold_forced ? 14'h0000 : holding_time_q; // RULE6
  assign active_low_polarity = output_polarity_q & ~pol_locked; // RULE9

  // ****************************************
  // Timing
  // ****************************************
  ms_tick_gen #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  edge_timer u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick),
    .event_in (ev_sel),
    .delay_ms (delay_eff),
    .hold_ms  (hold_eff),
    .active   (tm_active)
  );

  // ****************************************
  // APB slave and registers
  // ****************************************
  assign setup      = psel & ~penable;
  assign wr_en      = psel & penable & pwrite & pready_q;
  assign new_asg    = pwdata[3:0];
  assign new_locked = is_locked(is_contactor(new_asg) ? assign_q : new_asg);

  always_comb
  begin
    assign_d                 = assign_q;
    output_polarity_d        = output_polarity_q;
    analog_as_logic_select_d = analog_as_logic_select_q;
    activation_delay_d       = activation_delay_q;
    holding_time_d           = holding_time_q;
    refuse_ev                = 1'b0;
    refused_d                = refused_q;
    if (wr_en)
    begin
      case (paddr)
        CTRL_OFF:
        begin
          if (is_contactor(new_asg))
            refuse_ev = 1'b1; // RULE11
          else
            assign_d = new_asg;
          if (pwdata[CTRL_POL_BIT] && new_locked)
          begin
            output_polarity_d = 1'b0; // RULE9
            refuse_ev         = 1'b1;
          end
          else
            output_polarity_d = pwdata[CTRL_POL_BIT];
          analog_as_logic_select_d = pwdata[CTRL_SEL_BIT];
        end
        DELAY_OFF:
        begin
          if (pwdata[13:0] > TIME_MAX_MS || pwdata[31:14] != 18'h00000)
            refuse_ev = 1'b1;
          else
            activation_delay_d = pwdata[13:0]; // RULE3
        end
        HOLD_OFF:
        begin
          if (pwdata[13:0] > TIME_MAX_MS || pwdata[31:14] != 18'h00000)
            refuse_ev = 1'b1;
          else
            holding_time_d = pwdata[13:0]; // RULE5
        end
        STATUS_OFF:
          if (pwdata[ST_REFUSE_BIT])
            refused_d = 1'b0;
        APPFN_OFF:
          assign_d = new_asg; // RULE11
        default:
          refuse_ev = 1'b0;
      endcase
    end
    if (refuse_ev)
      refused_d = 1'b1;
  end

  always_comb
  begin
    pready_d  = setup;
    pslverr_d = 1'b0;
    prdata_d  = 32'h00000000;
    if (setup)
    begin
      case (paddr)
        CTRL_OFF:   prdata_d = {26'h0000000, analog_as_logic_select_q,
                                output_polarity_q, assign_q};
        DELAY_OFF:  prdata_d = {18'h00000, delay_eff};
        HOLD_OFF:   prdata_d = {18'h00000, hold_eff};
        STATUS_OFF: prdata_d = {25'h0000000, pol_locked, hold_forced, delay_forced,
                                refused_q, logic_out_q, tm_active, ev_sel};
        APPFN_OFF:  prdata_d = {28'h0000000, assign_q};
        default:    pslverr_d = 1'b1;
      endcase
    end
  end

  // ****************************************
  // Output conditioning
  // ****************************************
  always_comb
  begin
    logic_out_d = tm_active ^ active_low_polarity; // RULE7 RULE8
    if (analog_as_logic_select_q)
      ao_d = logic_out_d ? AO_MAX : AO_MIN; // RULE1 RULE2
    else
      ao_d = analog_level_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      assign_q                 <= ASSIGN_RST; // RULE10
      output_polarity_q        <= POL_RST;
      analog_as_logic_select_q <= SEL_RST;
      activation_delay_q       <= DELAY_RST;
      holding_time_q           <= HOLD_RST;
      refused_q                <= 1'b0;
      prdata_q                 <= 32'h00000000;
      pready_q                 <= 1'b0;
      pslverr_q                <= 1'b0;
      logic_out_q              <= 1'b0;
      ao_q                     <= AO_MIN;
    end
    else
    begin
      assign_q                 <= assign_d;
      output_polarity_q        <= output_polarity_d;
      analog_as_logic_select_q <= analog_as_logic_select_d;
      activation_delay_q       <= activation_delay_d;
      holding_time_q           <= holding_time_d;
      refused_q                <= refused_d;
      prdata_q                 <= prdata_d;
      pready_q                 <= pready_d;
      pslverr_q                <= pslverr_d;
      logic_out_q              <= logic_out_d;
      ao_q                     <= ao_d;
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign logic_out           = logic_out_q;
  assign first_analog_output = ao_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_ao_min;
    @(posedge pclk) disable iff (!presetn)
    $past(analog_as_logic_select_q) && !logic_out_q |-> first_analog_output == AO_MIN;
  endproperty
  a_ao_min: assert property (p_ao_min) // RULE1
    else $error("logic 0 not at minimum level");

  property p_ao_max;
    @(posedge pclk) disable iff (!presetn)
    $past(analog_as_logic_select_q) && logic_out_q |-> first_analog_output == AO_MAX;
  endproperty
  a_ao_max: assert property (p_ao_max) // RULE2
    else $error("logic 1 not at maximum level");

  property p_delay_forced;
    @(posedge pclk) disable iff (!presetn)
    delay_forced && ev_sel && !tm_active |=> tm_active;
  endproperty
  a_delay_forced: assert property (p_delay_forced) // RULE4
    else $error("delay not forced to zero");

  property p_hold_forced;
    @(posedge pclk) disable iff (!presetn)
    hold_forced && tm_active && !ev_sel |=> !tm_active;
  endproperty
  a_hold_forced: assert property (p_hold_forced) // RULE6
    else $error("holding time not forced to zero");

  property p_pos_pol;
    @(posedge pclk) disable iff (!presetn)
    !active_low_polarity && tm_active |=> logic_out_q;
  endproperty
  a_pos_pol: assert property (p_pos_pol) // RULE7
    else $error("positive polarity output not high");

  property p_neg_pol;
    @(posedge pclk) disable iff (!presetn)
    active_low_polarity |=> logic_out_q == !$past(tm_active);
  endproperty
  a_neg_pol: assert property (p_neg_pol) // RULE8
    else $error("negative polarity output wrong");

  property p_pol_lock;
    @(posedge pclk) disable iff (!presetn)
    pol_locked |=> logic_out_q == $past(tm_active);
  endproperty
  a_pol_lock: assert property (p_pol_lock) // RULE9
    else $error("locked assignment shows negative polarity");

  property p_default_asg;
    @(posedge pclk)
    $rose(presetn) |-> assign_q == ASG_OUTPUT && !output_polarity_q;
  endproperty
  a_default_asg: assert property (p_default_asg) // RULE10
    else $error("assignment not output contactor after reset");

  sequence s_ctrl_contactor_wr;
    wr_en && paddr == CTRL_OFF && is_contactor(pwdata[3:0]);
  endsequence

  property p_ctrl_refuse;
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_contactor_wr |=> assign_q == $past(assign_q) && refused_q;
  endproperty
  a_ctrl_refuse: assert property (p_ctrl_refuse) // RULE11
    else $error("contactor selection accepted from assignment register");

endmodule : logic_output_conditioner
`default_nettype wire

// *** test/contactor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module contactor_model
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic coil,
  output logic      closed
);
  // ****************************************
  // Contacts follow the coil one cycle late
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      closed <= 1'b0;
    else
      closed <= coil;
  end
endmodule : contactor_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import lo_cond_pkg::*;
;
  localparam int unsigned TK = 10;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] event_in;
  logic [15:0] analog_level_in;
  logic        logic_out;
  logic [15:0] first_analog_output;
  logic        closed;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          n_tests;
  int          cycles;
  int          n;

  // ****************************************
  // Design and far side
  // ****************************************
  logic_output_conditioner #(.TICK_CYC(TK)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .analog_level_in(analog_level_in), .logic_out(logic_out),
    .first_analog_output(first_analog_output)
  );
  contactor_model u_contactor
  (
    .pclk(pclk), .presetn(presetn), .coil(logic_out), .closed(closed)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_for(input logic [16:0] exp);
    n = 0;
    @(negedge pclk);
    while (({logic_out, first_analog_output} !== exp) && (n < 300))
    begin
      @(negedge pclk);
      n++;
    end
    chk({15'h0, logic_out, first_analog_output}, {15'h0, exp});
    @(posedge pclk);
  endtask : wait_for

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if ((fail_count == 0) && (n_tests > 0))
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk({31'h0, logic_out}, 32'h0);
    chk({16'h0, first_analog_output}, {16'h0, AO_MIN});
    apb(1'b0, CTRL_OFF, 32'h0);
    chk(rd, 32'h24);
    apb(1'b0, DELAY_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, HOLD_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_out_contactor;
    apb(1'b1, DELAY_OFF, 32'h5);
    apb(1'b1, HOLD_OFF, 32'h3);
    apb(1'b0, DELAY_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, HOLD_OFF, 32'h0);
    chk(rd, 32'h3);
    event_in <= 16'h0010;
    wait_for({1'b1, AO_MAX});
    chk({31'h0, n <= 2}, 32'h1);
    @(negedge pclk);
    chk({31'h0, closed}, 32'h1);
    @(posedge pclk);
    event_in <= 16'h0000;
    wait_for({1'b0, AO_MIN});
    chk({31'h0, (n >= 20) && (n <= 33)}, 32'h1);
    $display("test output contactor done");
  endtask : t_out_contactor

  task automatic t_locked;
    apb(1'b1, CTRL_OFF, 32'h22);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk(rd, 32'h24);
    apb(1'b1, STATUS_OFF, 32'h8);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk({31'h0, rd[ST_REFUSE_BIT]}, 32'h0);
    apb(1'b1, APPFN_OFF, 32'h2);
    apb(1'b1, CTRL_OFF, 32'h32);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk(rd, 32'h22);
    apb(1'b1, HOLD_OFF, 32'h4);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk({28'h0, rd[6:3]}, 32'hf);
    event_in <= 16'h0004;
    wait_for({1'b1, AO_MAX});
    chk({31'h0, n <= 2}, 32'h1);
    event_in <= 16'h0000;
    wait_for({1'b0, AO_MIN});
    chk({31'h0, n <= 2}, 32'h1);
    apb(1'b1, APPFN_OFF, 32'h1);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk({28'h0, rd[6:3]}, 32'hf);
    apb(1'b1, APPFN_OFF, 32'h0);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk({28'h0, rd[6:3]}, 32'h1);
    $display("test locked assignment done");
  endtask : t_locked

  task automatic t_delay;
    apb(1'b1, CTRL_OFF, 32'h26);
    apb(1'b1, DELAY_OFF, 32'h4);
    apb(1'b1, HOLD_OFF, 32'h0);
    event_in <= 16'h0040;
    wait_for({1'b1, AO_MAX});
    chk({31'h0, (n >= 30) && (n <= 43)}, 32'h1);
    event_in <= 16'h0000;
    wait_for({1'b0, AO_MIN});
    event_in <= 16'h0040;
    repeat (25) @(posedge pclk);
    event_in <= 16'h0000;
    repeat (3) @(posedge pclk);
    chk({31'h0, logic_out}, 32'h0);
    event_in <= 16'h0040;
    wait_for({1'b1, AO_MAX});
    chk({31'h0, n >= 30}, 32'h1);
    event_in <= 16'h0000;
    wait_for({1'b0, AO_MIN});
    $display("test delay done");
  endtask : t_delay

  task automatic t_polarity;
    apb(1'b1, DELAY_OFF, 32'h0);
    apb(1'b1, CTRL_OFF, 32'h36);
    wait_for({1'b1, AO_MAX});
    event_in <= 16'h0040;
    wait_for({1'b0, AO_MIN});
    apb(1'b1, CTRL_OFF, 32'h16);
    wait_for({1'b0, 16'h1234});
    event_in <= 16'h0000;
    apb(1'b1, CTRL_OFF, 32'h26);
    wait_for({1'b0, AO_MIN});
    $display("test polarity done");
  endtask : t_polarity

  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 8'h00;
    pwdata          = 32'h0;
    event_in        = 16'h0000;
    analog_level_in = 16'h1234;
    fail_count      = 0;
    n_tests         = 0;
    cycles          = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_out_contactor();
    t_locked();
    t_delay();
    t_polarity();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
